// ===== common/pmcap_defs.svh
// Constants of the power management capability register pair.
// Assumes byte offsets within the function's configuration space.
`ifndef PMCAP_DEFS_SVH
`define PMCAP_DEFS_SVH

// Register byte offsets
`define PMCAP_OFS_CAPS        8'h52
`define PMCAP_OFS_CTRL        8'h54

// Reset values
`define PMCAP_CAPS_RESET      16'h0602
`define PMCAP_CTRL_RESET      16'h0000

// Capabilities word: fixed part with both D1 and D2 advertised
`define PMCAP_CAPS_FIXED      16'h0600
`define PMCAP_CAPS_VER_LSB    0
`define PMCAP_CAPS_VER_MSB    2
`define PMCAP_VER_OLD         3'h2
`define PMCAP_VER_NEW         3'h3

// Control/status word fields
`define PMCAP_CS_LEVEL_LSB    0
`define PMCAP_CS_LEVEL_MSB    1
`define PMCAP_CS_NSR_BIT      3
`define PMCAP_CS_SCRATCH_BIT  8

// Byte lanes of the 16-bit access port
`define PMCAP_BE_LOW          0
`define PMCAP_BE_HIGH         1

`endif

// ===== common/pmcap_pkg.sv
// Types of the power management capability register pair.
// Assumes nothing of its surroundings.
package pmcap_pkg;

  typedef enum logic [1:0] {
    PMCAP_D0     = 2'b00,
    PMCAP_D1     = 2'b01,
    PMCAP_D2     = 2'b10,
    PMCAP_D3_HOT = 2'b11
  } pmcap_level_e;

  typedef logic [15:0] pmcap_word_t;

endpackage : pmcap_pkg

// ===== core/pmcap_ctrl_store.sv
// Storage of the writable control/status fields.
// Assumes the parent has already decoded address and byte lanes.
`timescale 1ns/1ps

module pmcap_ctrl_store (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // Write strobes and data
  input  wire logic                  i_level_we,
  input  wire pmcap_pkg::pmcap_level_e i_level_d,
  input  wire logic                  i_scratch_we,
  input  wire logic                  i_scratch_d,
  // Stored state
  output logic                       o_level,
  output pmcap_pkg::pmcap_level_e    o_level_val,
  output logic                       o_scratch
);
  import pmcap_pkg::*;

  pmcap_level_e level_q;
  pmcap_level_e level_d;
  logic         scratch_q;
  logic         scratch_d;

  // Only the decoded strobes change state; the reset is the sole other path
  always_comb begin
    level_d   = i_level_we ? i_level_d : level_q;
    scratch_d = i_scratch_we ? i_scratch_d : scratch_q;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      level_q   <= PMCAP_D0;
      scratch_q <= 1'b0;
    end else begin
      level_q   <= level_d;
      scratch_q <= scratch_d;
    end
  end

  assign o_level     = (level_q != PMCAP_D0);
  assign o_level_val = level_q;
  assign o_scratch   = scratch_q;

endmodule : pmcap_ctrl_store

// ===== core/pmcap_regs.sv
// Power management capabilities and control/status registers.
// Assumes a 16-bit configuration access port, one access per cycle,
// synchronous to i_clk; the revision select bit comes from another block.
//
// Behaviour
// - Capabilities bits 15:11 (wake state mask) always read zero.
// - Capabilities bit 10 reads one: state D2 supported.
// - Capabilities bit 9 reads one: state D1 supported.
// - Capabilities bits 8:6, auxiliary current, always read zero.
// - Capabilities bit 5, special initialisation, reads zero.
// - Capabilities bit 3, wake needs clock, reads zero.
// - Revision field reads 010b, or 011b when revision select is set.
// - Control/status bit 15, wake event flag, is read-only zero.
// - Control/status data scale and data select fields always read zero.
// - Bit 8 is writable scratch storage, no side effect, resets to zero.
// - No-soft-reset bit reads the revision select bit.
// - Leaving D3hot for D0 causes no reset; all contents are kept.
// - Bits 1:0 hold the power level, written by software, reset D0.
// - Reserved control bits 7:4, 2 and capabilities bit 4 read zero.
`timescale 1ns/1ps
`include "pmcap_defs.svh"

module pmcap_regs (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  // Configuration access port
  input  wire logic [7:0]              i_cfg_addr,
  input  wire logic                    i_cfg_rd,
  input  wire logic                    i_cfg_wr,
  input  wire logic [1:0]              i_cfg_be,
  input  wire logic [15:0]             i_cfg_wdata,
  output pmcap_pkg::pmcap_word_t       o_cfg_rdata,
  output logic                         o_cfg_rvalid,
  // Revision select from the general control register
  input  wire logic                    i_revision_select_bit,
  // Function state
  output pmcap_pkg::pmcap_level_e      o_current_power_level,
  output logic                         o_wake_scratch_bit
);
  import pmcap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:1] == ofs[7:1]);
  endfunction : hit

  logic          ctrl_hit;
  logic          caps_hit;
  logic          level_we;
  logic          scratch_we;
  pmcap_level_e  level_wval;
  pmcap_level_e  level_val;
  logic          scratch_val;
  logic          level_nonzero;
  pmcap_word_t   caps_word;
  pmcap_word_t   ctrl_word;

  assign ctrl_hit   = hit(i_cfg_addr, `PMCAP_OFS_CTRL);
  assign caps_hit   = hit(i_cfg_addr, `PMCAP_OFS_CAPS);
  // Only the level and scratch lanes store; every other bit is dropped
  assign level_we   = i_cfg_wr && ctrl_hit && i_cfg_be[`PMCAP_BE_LOW];
  assign scratch_we = i_cfg_wr && ctrl_hit && i_cfg_be[`PMCAP_BE_HIGH];
  assign level_wval = pmcap_level_e'(i_cfg_wdata[`PMCAP_CS_LEVEL_MSB:`PMCAP_CS_LEVEL_LSB]);

  ////////////////////////////////////////////////////////////////////////////
  // Stored fields

  // Any level may be written at any time; D3hot to D0 resets nothing
  pmcap_ctrl_store u_store (
    .i_clk        (i_clk),
    .i_resetn     (i_resetn),
    .i_level_we   (level_we),
    .i_level_d    (level_wval),
    .i_scratch_we (scratch_we),
    .i_scratch_d  (i_cfg_wdata[`PMCAP_CS_SCRATCH_BIT]),
    .o_level      (level_nonzero),
    .o_level_val  (level_val),
    .o_scratch    (scratch_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Readback words

  always_comb begin
    caps_word = `PMCAP_CAPS_FIXED;
    caps_word[`PMCAP_CAPS_VER_MSB:`PMCAP_CAPS_VER_LSB] =
      i_revision_select_bit ? `PMCAP_VER_NEW : `PMCAP_VER_OLD;
    // Bits 8:3 stay zero: aux current, init, reserved, clock
    ctrl_word = 16'h0000;
    ctrl_word[`PMCAP_CS_LEVEL_MSB:`PMCAP_CS_LEVEL_LSB] = level_val;
    ctrl_word[`PMCAP_CS_NSR_BIT]     = i_revision_select_bit;
    ctrl_word[`PMCAP_CS_SCRATCH_BIT] = scratch_val;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  pmcap_word_t rdata_q;
  pmcap_word_t rdata_d;
  logic        rvalid_q;
  logic        rvalid_d;
  pmcap_level_e level_out_q;
  pmcap_level_e level_out_d;
  logic        scratch_out_q;
  logic        scratch_out_d;

  always_comb begin
    rvalid_d = i_cfg_rd;
    rdata_d  = 16'h0000;
    if (i_cfg_rd && caps_hit) begin
      rdata_d = caps_word;
    end else if (i_cfg_rd && ctrl_hit) begin
      rdata_d = ctrl_word;
    end
    level_out_d   = level_val;
    scratch_out_d = scratch_val;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q       <= 16'h0000;
      rvalid_q      <= 1'b0;
      level_out_q   <= PMCAP_D0;
      scratch_out_q <= 1'b0;
    end else begin
      rdata_q       <= rdata_d;
      rvalid_q      <= rvalid_d;
      level_out_q   <= level_out_d;
      scratch_out_q <= scratch_out_d;
    end
  end

  assign o_cfg_rdata           = rdata_q;
  assign o_cfg_rvalid          = rvalid_q;
  assign o_current_power_level = level_out_q;
  assign o_wake_scratch_bit    = scratch_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_rd_caps;
    i_cfg_rd && i_cfg_addr[7:1] == 7'h29;
  endsequence

  sequence s_rd_ctrl;
    i_cfg_rd && i_cfg_addr[7:1] == 7'h2A;
  endsequence

  // Lower lane drops D3hot to D0 while the scratch lane is left alone
  sequence s_leave_d3;
    level_val == PMCAP_D3_HOT && level_we && !scratch_we && i_cfg_wdata[1:0] == 2'h0;
  endsequence

  AST_CAPS_WAKE_ZERO: assert property (
      s_rd_caps |=> o_cfg_rvalid && o_cfg_rdata[15:11] == 5'h00)
    else $error("wake state mask not zero");
  AST_CAPS_D2: assert property (s_rd_caps |=> o_cfg_rdata[10])
    else $error("D2 capability not advertised");
  AST_CAPS_D1: assert property (s_rd_caps |=> o_cfg_rdata[9])
    else $error("D1 capability not advertised");
  AST_CAPS_AUX_ZERO: assert property (s_rd_caps |=> o_cfg_rdata[8:6] == 3'h0)
    else $error("aux current field not zero");
  AST_CAPS_INIT_ZERO: assert property (s_rd_caps |=> !o_cfg_rdata[5])
    else $error("special init bit set");
  AST_CAPS_CLOCK_ZERO: assert property (s_rd_caps |=> !o_cfg_rdata[3])
    else $error("wake needs clock bit set");
  AST_CAPS_REVISION: assert property (
      s_rd_caps |=> o_cfg_rdata[2:0] == ($past(i_revision_select_bit) ? 3'h3 : 3'h2))
    else $error("revision field wrong");
  AST_CTRL_WAKE_FLAG: assert property (
      s_rd_ctrl |=> o_cfg_rvalid && !o_cfg_rdata[15])
    else $error("wake event flag set");
  AST_CTRL_DATA_ZERO: assert property (s_rd_ctrl |=> o_cfg_rdata[14:9] == 6'h00)
    else $error("data scale or select not zero");
  AST_SCRATCH_WRITE: assert property (
      scratch_we |=> ##1 o_wake_scratch_bit == $past(i_cfg_wdata[8], 2))
    else $error("scratch bit not stored");
  AST_CTRL_NSR: assert property (
      s_rd_ctrl |=> o_cfg_rdata[3] == $past(i_revision_select_bit))
    else $error("no-soft-reset bit wrong");
  AST_D3_TO_D0_KEEP: assert property (
      s_leave_d3 |=> ##1 o_current_power_level == PMCAP_D0
      && o_wake_scratch_bit == $past(scratch_val, 2))
    else $error("contents lost leaving D3hot");
  AST_LEVEL_WRITE: assert property (
      level_we |=> ##1 o_current_power_level == pmcap_level_e'($past(i_cfg_wdata[1:0], 2)))
    else $error("power level not stored");
  AST_LEVEL_OUT: assert property (
      level_nonzero |=> o_current_power_level != PMCAP_D0)
    else $error("power level output lost a stored non-D0 level");
  AST_RESERVED_ZERO: assert property (
      (s_rd_ctrl or s_rd_caps) |=> o_cfg_rdata[7:4] == 4'h0 && !o_cfg_rdata[2])
    else $error("reserved bits not zero");
  AST_IGNORED_WRITE: assert property (
      !(level_we || scratch_we) |=> $stable(level_val) && $stable(scratch_val))
    else $error("state changed without a writable lane");

endmodule : pmcap_regs

// ===== sim/tb_top.sv
// Self-checking bench of the power management capability register pair.
// Assumes the access port contract: one-cycle read latency, writes stored at the taking edge.
`timescale 1ns/1ps
`include "pmcap_defs.svh"

module tb_top;
  import pmcap_pkg::*;

  logic         i_clk;
  logic         i_resetn;
  logic [7:0]   i_cfg_addr;
  logic         i_cfg_rd;
  logic         i_cfg_wr;
  logic [1:0]   i_cfg_be;
  logic [15:0]  i_cfg_wdata;
  logic         i_revision_select_bit;
  pmcap_word_t  o_cfg_rdata;
  logic         o_cfg_rvalid;
  pmcap_level_e o_current_power_level;
  logic         o_wake_scratch_bit;
  int           mismatches;
  int           checks_done;
  int           cycles;
  logic [15:0]  exp_v;

  pmcap_regs uut (
    .i_clk                 (i_clk),
    .i_resetn              (i_resetn),
    .i_cfg_addr            (i_cfg_addr),
    .i_cfg_rd              (i_cfg_rd),
    .i_cfg_wr              (i_cfg_wr),
    .i_cfg_be              (i_cfg_be),
    .i_cfg_wdata           (i_cfg_wdata),
    .o_cfg_rdata           (o_cfg_rdata),
    .o_cfg_rvalid          (o_cfg_rvalid),
    .i_revision_select_bit (i_revision_select_bit),
    .o_current_power_level (o_current_power_level),
    .o_wake_scratch_bit    (o_wake_scratch_bit)
  );

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Read and compare the returned halfword; rvalid must stand one cycle only
  task automatic cfg_read(input logic [7:0] addr, input logic [15:0] exp);
    @(posedge i_clk);
    i_cfg_addr <= addr;
    i_cfg_rd   <= 1'b1;
    @(posedge i_clk);
    i_cfg_rd   <= 1'b0;
    #1;
    check({15'h0000, o_cfg_rvalid}, 16'h0001);
    check(o_cfg_rdata, exp);
    @(posedge i_clk);
    #1;
    check({15'h0000, o_cfg_rvalid}, 16'h0000);
  endtask : cfg_read

  task automatic cfg_write(input logic [7:0] addr, input logic [1:0] be, input logic [15:0] d);
    @(posedge i_clk);
    i_cfg_addr  <= addr;
    i_cfg_be    <= be;
    i_cfg_wdata <= d;
    i_cfg_wr    <= 1'b1;
    @(posedge i_clk);
    i_cfg_wr    <= 1'b0;
  endtask : cfg_write

  // Compare the stored state outputs against level and scratch
  task automatic check_state(input logic [1:0] lvl, input logic scr);
    check({14'h0000, o_current_power_level}, {14'h0000, lvl});
    check({15'h0000, o_wake_scratch_bit}, {15'h0000, scr});
  endtask : check_state

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    i_resetn = 1'b0;
    i_cfg_addr = 8'h00;
    i_cfg_rd = 1'b0;
    i_cfg_wr = 1'b0;
    i_cfg_be = 2'h0;
    i_cfg_wdata = 16'h0000;
    i_revision_select_bit = 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    cfg_read(`PMCAP_OFS_CAPS, 16'h0602);
    cfg_read(`PMCAP_OFS_CTRL, 16'h0000);
    cfg_read(8'h60, 16'h0000);
    // Every power level, with both revision selections and junk in read-only bits
    for (int l = 0; l < 4; l++) begin
      i_revision_select_bit <= l[0];
      cfg_write(`PMCAP_OFS_CTRL, 2'h3, 16'hFEFC | (16'(l[1]) << 8) | 16'(l));
      exp_v = (16'(l[1]) << 8) | (16'(l[0]) << 3) | 16'(l);
      cfg_read(`PMCAP_OFS_CTRL, exp_v);
      cfg_read(`PMCAP_OFS_CAPS, l[0] ? 16'h0603 : 16'h0602);
      check_state(l[1:0], l[1]);
    end
    // Caps and unmapped writes change nothing; state is D3hot with scratch set
    cfg_write(`PMCAP_OFS_CAPS, 2'h3, 16'hFFFF);
    cfg_write(8'h56, 2'h3, 16'h0000);
    cfg_read(`PMCAP_OFS_CAPS, 16'h0603);
    cfg_read(`PMCAP_OFS_CTRL, 16'h010B);
    // High lane only: scratch clears, level untouched
    cfg_write(`PMCAP_OFS_CTRL, 2'h2, 16'h0000);
    cfg_read(`PMCAP_OFS_CTRL, 16'h000B);
    check_state(2'h3, 1'b0);
    // D3hot back to D0 keeps the scratch bit
    cfg_write(`PMCAP_OFS_CTRL, 2'h2, 16'h0100);
    cfg_write(`PMCAP_OFS_CTRL, 2'h1, 16'h0000);
    cfg_read(`PMCAP_OFS_CTRL, 16'h0108);
    check_state(2'h0, 1'b1);
    // Low lane with level bits only: scratch kept, level moves to D2
    cfg_write(`PMCAP_OFS_CTRL, 2'h1, 16'h0002);
    cfg_read(`PMCAP_OFS_CTRL, 16'h010A);
    // A second reset returns the stored fields to zero
    @(posedge i_clk);
    i_resetn <= 1'b0;
    @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
    check_state(2'h0, 1'b0);
    cfg_read(`PMCAP_OFS_CTRL, 16'h0008);
    print_verdict();
  end

endmodule : tb_top
